/* File: rtl/crt_pkg.sv */
// Package for the contactless RF timer block: widths, encodings, carriers.
// Assumes one system clock; RF rates arrive as enables, oscillators as pin levels.
package crt_pkg;
  localparam int CRT_TMR_W = 20;
  localparam int CRT_PRE_W = 8;
  localparam logic [CRT_TMR_W-1:0] CRT_TMR_RST = 20'h00000;
  localparam logic [2:0] CRT_PRE_RST = 3'h0;

  // Start trigger selection for the RF timers
  typedef enum logic [2:0] {
    CRT_ST_NOW = 3'h0,
    CRT_ST_FIELD_ON = 3'h1,
    CRT_ST_FIELD_OFF = 3'h2,
    CRT_ST_RX_START = 3'h3,
    CRT_ST_RX_END = 3'h4,
    CRT_ST_TX_START = 3'h5,
    CRT_ST_TX_END = 3'h6,
    CRT_ST_OSC_RUN = 3'h7
  } crt_start_t;

  // Timer run state
  typedef enum logic [1:0] {
    CRT_IDLE = 2'h0,
    CRT_ARMED = 2'h1,
    CRT_RUN = 2'h2
  } crt_state_t;

  // Per RF timer configuration
  typedef struct packed {
    logic [CRT_TMR_W-1:0] start_value;
    logic [2:0] prescale;
    crt_start_t trigger;
    logic reload;
    logic enable;
  } crt_cfg_t;

  // RF events, one-cycle pulses in the system clock domain
  typedef struct packed {
    logic field_on;
    logic field_off;
    logic rx_start;
    logic rx_end;
    logic tx_start;
    logic tx_end;
  } crt_evt_t;
endpackage : crt_pkg

/* File: rtl/crt_rf_timer.sv */
// One 20-bit RF timer: prescaled count-down with trigger and reload.
// Assumes tick_13m is a one-cycle enable at the contactless clock rate.
`timescale 1ns/100ps
module crt_rf_timer
  import crt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick_13m,
  input crt_pkg::crt_cfg_t cfg,
  input crt_pkg::crt_evt_t evt,
  input wire logic osc_running,
  input wire logic flag_clr,
  output logic [crt_pkg::CRT_TMR_W-1:0] count,
  output logic running,
  output logic expired_flag
);
  import crt_pkg::*;

  crt_state_t state_reg;
  logic [CRT_PRE_W-1:0] pre_reg;
  logic [CRT_TMR_W-1:0] cnt_reg;
  logic flag_reg;
  logic enable_d_reg;

  // Prescaler: divide by 2 << prescale, i.e. 2..256
  wire [CRT_PRE_W-1:0] pre_max = CRT_PRE_W'((9'h002 << cfg.prescale) - 9'h001);
  wire pre_tick = tick_13m && (pre_reg == pre_max);
  wire arm = cfg.enable && !enable_d_reg;

  // Trigger decode
  logic trig_hit;
  always_comb begin
    case (cfg.trigger)
      CRT_ST_NOW: trig_hit = 1'b1;
      CRT_ST_FIELD_ON: trig_hit = evt.field_on;
      CRT_ST_FIELD_OFF: trig_hit = evt.field_off;
      CRT_ST_RX_START: trig_hit = evt.rx_start;
      CRT_ST_RX_END: trig_hit = evt.rx_end;
      CRT_ST_TX_START: trig_hit = evt.tx_start;
      CRT_ST_TX_END: trig_hit = evt.tx_end;
      CRT_ST_OSC_RUN: trig_hit = osc_running;
      default: trig_hit = 1'b0;
    endcase
  end

  wire expire = (state_reg == CRT_RUN) && pre_tick && (cnt_reg == '0);

  // Enable edge detector, so one write arms once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_d_reg <= 1'b0;
    end else begin
      enable_d_reg <= cfg.enable;
    end
  end

  // Count-down core; clearing enable stops at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CRT_IDLE;
      pre_reg <= '0;
      cnt_reg <= CRT_TMR_RST;
    end else if (!cfg.enable) begin
      state_reg <= CRT_IDLE;
    end else begin
      case (state_reg)
        CRT_IDLE: begin
          if (arm) begin
            state_reg <= CRT_ARMED;
          end
        end
        CRT_ARMED: begin
          if (trig_hit) begin
            state_reg <= CRT_RUN;
            pre_reg <= '0;
            cnt_reg <= cfg.start_value;
          end
        end
        CRT_RUN: begin
          if (tick_13m) begin
            pre_reg <= pre_tick ? '0 : pre_reg + 1'b1;
          end
          if (expire) begin
            cnt_reg <= cfg.start_value;
            state_reg <= cfg.reload ? CRT_RUN : CRT_IDLE;
          end else if (pre_tick) begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= CRT_IDLE;
      endcase
    end
  end

  // Sticky expiry flag; a new expiry beats a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (expire) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  assign count = cnt_reg;
  assign running = (state_reg == CRT_RUN);
  assign expired_flag = flag_reg;

  property p_flag_on_expire;
    @(posedge clk) disable iff (!rst_n) expire |=> flag_reg;
  endproperty
  a_flag_on_expire: assert property (p_flag_on_expire)
    else $error("expiry flag not set");

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
      expire && cfg.reload && cfg.enable |=> running;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload did not keep running");

  property p_stop;
    @(posedge clk) disable iff (!rst_n) expire && !cfg.reload |=> !running;
  endproperty
  a_stop: assert property (p_stop)
    else $error("timer kept running without reload");

  property p_prescale_hold;
    @(posedge clk) disable iff (!rst_n)
      running && !pre_tick && $stable(cfg.enable) |=> $stable(cnt_reg);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold)
    else $error("count moved without prescaler tick");

  property p_trigger;
    @(posedge clk) disable iff (!rst_n)
      state_reg == CRT_ARMED && cfg.enable && trig_hit
      |=> running && cnt_reg == $past(cfg.start_value);
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger did not start timer");
endmodule : crt_rf_timer

/* File: rtl/crt_timers.sv */
// Top of the contactless RF timers: three RF timers and the trim timer.
// Assumes a 27.12 MHz source enable from PLL or field recovery and
// oscillator edges arriving as asynchronous levels on pins.
//
// Contract
// - Three RF timers, twenty bits each, clocked from contactless clock.
// - RF timer prescaler divides contactless clock by 2 up to 256.
// - RF start trigger: now, field on/off, rx or tx start/end.
// - RF timer may also start when the trim timer runs.
// - Every expiry sets that timer's flag and raises the interrupt.
// - Trim timer is twenty bits, clocked by low or high oscillator.
// - Trim timer works only while the contactless clock is present.
// - Trim timer has only a software immediate start.
// - Contactless clock is 27.12 MHz source halved, PLL or recovered.
`timescale 1ns/100ps
module crt_timers
  import crt_pkg::*;
#(
  parameter int NUM_RF = 3
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick_pll_27m,
  input wire logic tick_rf_27m,
  input wire logic clk_src_rf,
  input wire logic rf_clock_present,
  input wire logic lfo_pin,
  input wire logic hfo_pin,
  input crt_pkg::crt_evt_t rf_events,
  input crt_pkg::crt_cfg_t rf_timer_a_cfg,
  input crt_pkg::crt_cfg_t rf_timer_b_cfg,
  input crt_pkg::crt_cfg_t rf_timer_c_cfg,
  input wire logic [2:0] rf_flag_clr,
  input wire logic osc_trim_start,
  input wire logic osc_trim_stop,
  input wire logic osc_trim_sel_hfo,
  input wire logic [crt_pkg::CRT_TMR_W-1:0] osc_trim_start_value,
  input wire logic osc_trim_flag_clr,
  output logic [crt_pkg::CRT_TMR_W-1:0] rf_timer_a_count,
  output logic [crt_pkg::CRT_TMR_W-1:0] rf_timer_b_count,
  output logic [crt_pkg::CRT_TMR_W-1:0] rf_timer_c_count,
  output logic [2:0] rf_running,
  output logic [2:0] rf_expired,
  output logic [crt_pkg::CRT_TMR_W-1:0] osc_trim_timer_count,
  output logic osc_trim_running,
  output logic osc_trim_expired,
  output logic irq
);
  import crt_pkg::*;

  // Reset release through two flops
  logic [1:0] rst_sync_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_reg[1];

  // Halve the selected 27.12 MHz source to the contactless rate
  logic half_reg;
  wire src_tick = clk_src_rf ? tick_rf_27m : tick_pll_27m;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_reg <= 1'b0;
    end else if (src_tick) begin
      half_reg <= ~half_reg;
    end
  end
  wire tick_13m = src_tick && half_reg;

  // Oscillator pins: three flops, a change counts when 2nd and 3rd agree
  logic [2:0] lfo_sync_reg;
  logic [2:0] hfo_sync_reg;
  logic osc_level_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfo_sync_reg <= 3'h0;
      hfo_sync_reg <= 3'h0;
      osc_level_reg <= 1'b0;
    end else begin
      lfo_sync_reg <= {lfo_sync_reg[1:0], lfo_pin};
      hfo_sync_reg <= {hfo_sync_reg[1:0], hfo_pin};
      if (osc_trim_sel_hfo ? (hfo_sync_reg[1] == hfo_sync_reg[2])
                           : (lfo_sync_reg[1] == lfo_sync_reg[2])) begin
        osc_level_reg <= osc_trim_sel_hfo ? hfo_sync_reg[2] : lfo_sync_reg[2];
      end
    end
  end
  // Oscillator select; hfo near the system rate only counts when sampled
  // Switching source while running may lose or add one edge
  wire osc_sel_lvl = osc_trim_sel_hfo ? hfo_sync_reg[2] : lfo_sync_reg[2];
  wire osc_agree = osc_trim_sel_hfo ? (hfo_sync_reg[1] == hfo_sync_reg[2])
                                    : (lfo_sync_reg[1] == lfo_sync_reg[2]);
  wire osc_tick = osc_agree && osc_sel_lvl && !osc_level_reg;

  // One oscillator edge must give one tick, never two
  property p_osc_once;
    @(posedge clk) disable iff (!rst_n) osc_tick |=> !osc_tick;
  endproperty
  a_osc_once: assert property (p_osc_once)
    else $error("one oscillator edge counted twice");

  // RF timer instances
  crt_cfg_t cfg_arr [NUM_RF];
  logic [CRT_TMR_W-1:0] cnt_arr [NUM_RF];
  assign cfg_arr[0] = rf_timer_a_cfg;
  assign cfg_arr[1] = rf_timer_b_cfg;
  assign cfg_arr[2] = rf_timer_c_cfg;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RF; gi++) begin : g_rf
      crt_rf_timer u_rf (
        .clk(clk),
        .rst_n(rst_n),
        .tick_13m(tick_13m),
        .cfg(cfg_arr[gi]),
        .evt(rf_events),
        .osc_running(osc_trim_running),
        .flag_clr(rf_flag_clr[gi]),
        .count(cnt_arr[gi]),
        .running(rf_running[gi]),
        .expired_flag(rf_expired[gi])
      );
    end
  endgenerate
  assign rf_timer_a_count = cnt_arr[0];
  assign rf_timer_b_count = cnt_arr[1];
  assign rf_timer_c_count = cnt_arr[2];

  // Trim timer: software start only, halts without contactless clock
  logic trim_run_reg;
  logic [CRT_TMR_W-1:0] trim_cnt_reg;
  logic trim_flag_reg;
  wire trim_ok = rf_clock_present;
  wire trim_expire = trim_run_reg && trim_ok && osc_tick
                     && (trim_cnt_reg == '0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_run_reg <= 1'b0;
      trim_cnt_reg <= CRT_TMR_RST;
    end else if (osc_trim_stop) begin
      trim_run_reg <= 1'b0;
    end else if (osc_trim_start && trim_ok) begin
      trim_run_reg <= 1'b1;
      trim_cnt_reg <= osc_trim_start_value;
    end else if (trim_expire) begin
      trim_run_reg <= 1'b0;
    end else if (trim_run_reg && trim_ok && osc_tick) begin
      trim_cnt_reg <= trim_cnt_reg - 1'b1;
    end
  end

  // Sticky trim flag; set beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_flag_reg <= 1'b0;
    end else if (trim_expire) begin
      trim_flag_reg <= 1'b1;
    end else if (osc_trim_flag_clr) begin
      trim_flag_reg <= 1'b0;
    end
  end

  assign osc_trim_timer_count = trim_cnt_reg;
  assign osc_trim_running = trim_run_reg;
  assign osc_trim_expired = trim_flag_reg;
  assign irq = |rf_expired || trim_flag_reg;

  property p_half;
    @(posedge clk) disable iff (!rst_n) tick_13m |=> !tick_13m;
  endproperty
  a_half: assert property (p_half)
    else $error("contactless tick not halved");

  property p_trim_no_clock;
    @(posedge clk) disable iff (!rst_n)
      !rf_clock_present && !osc_trim_start |=> $stable(trim_cnt_reg);
  endproperty
  a_trim_no_clock: assert property (p_trim_no_clock)
    else $error("trim timer moved without contactless clock");

  // A start request without contactless clock must not wake the timer
  property p_trim_refused;
    @(posedge clk) disable iff (!rst_n)
      !rf_clock_present && !trim_run_reg |=> !trim_run_reg;
  endproperty
  a_trim_refused: assert property (p_trim_refused)
    else $error("trim timer started without contactless clock");

  // Trim start: a granted request, then a running timer holding the value
  sequence s_trim_req;
    osc_trim_start && !osc_trim_stop && rf_clock_present;
  endsequence
  sequence s_trim_loaded;
    trim_run_reg && trim_cnt_reg == $past(osc_trim_start_value);
  endsequence
  property p_trim_start;
    @(posedge clk) disable iff (!rst_n)
      s_trim_req |=> s_trim_loaded;
  endproperty
  a_trim_start: assert property (p_trim_start)
    else $error("trim timer did not start");

  property p_trim_flag;
    @(posedge clk) disable iff (!rst_n) trim_expire |=> trim_flag_reg ##0 irq;
  endproperty
  a_trim_flag: assert property (p_trim_flag)
    else $error("trim expiry did not raise irq");

  property p_trim_step;
    @(posedge clk) disable iff (!rst_n)
      trim_run_reg && !trim_expire && osc_tick && rf_clock_present
      && !osc_trim_start && !osc_trim_stop
      |=> trim_cnt_reg == $past(trim_cnt_reg) - 20'h00001;
  endproperty
  a_trim_step: assert property (p_trim_step)
    else $error("trim count did not step");
endmodule : crt_timers

/* File: testbench/contactless_rf_timers_tb_top.sv */
// Bench for the RF timer block: expiry timing, triggers, trim timer.
// Assumes crt_pkg and crt_timers compiled first; one 50 MHz clock.
`timescale 1ns/100ps
module contactless_rf_timers_tb_top;
  import crt_pkg::*;
  logic clk, resetn, clk_src_rf;
  logic tick_pll_27m = 1'b0;
  logic tick_rf_27m = 1'b0;
  logic rf_clock_present, lfo_pin, hfo_pin, pll_on, rf_on;
  logic t_start, t_stop, t_hfo, t_fclr;
  logic [19:0] t_sv, tcnt;
  logic [19:0] cnt [3];
  logic [2:0] fclr, run, exp_f;
  logic [3:0] odiv = 4'h0;
  logic t_run, t_exp, irq;
  crt_evt_t ev;
  crt_cfg_t cfg [3];
  int n_mismatch, checked;
  logic [31:0] seed;

  crt_timers uut (.clk(clk), .resetn(resetn), .tick_pll_27m(tick_pll_27m),
    .tick_rf_27m(tick_rf_27m), .clk_src_rf(clk_src_rf),
    .rf_clock_present(rf_clock_present), .lfo_pin(lfo_pin),
    .hfo_pin(hfo_pin), .rf_events(ev), .rf_timer_a_cfg(cfg[0]),
    .rf_timer_b_cfg(cfg[1]), .rf_timer_c_cfg(cfg[2]), .rf_flag_clr(fclr),
    .osc_trim_start(t_start), .osc_trim_stop(t_stop),
    .osc_trim_sel_hfo(t_hfo), .osc_trim_start_value(t_sv),
    .osc_trim_flag_clr(t_fclr), .rf_timer_a_count(cnt[0]),
    .rf_timer_b_count(cnt[1]), .rf_timer_c_count(cnt[2]),
    .rf_running(run), .rf_expired(exp_f), .osc_trim_timer_count(tcnt),
    .osc_trim_running(t_run), .osc_trim_expired(t_exp), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Source ticks and oscillator pins; rf ticks at half rate on purpose
  always @(posedge clk) begin
    tick_pll_27m <= pll_on;
    tick_rf_27m <= rf_on & ~tick_rf_27m;
    odiv <= odiv + 4'h1;
    lfo_pin <= odiv[3];
    hfo_pin <= odiv[1];
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // Model: (sv+1)*divide contactless ticks, two source ticks each
  task automatic expire(input int i, input int sv, input int p,
                        input logic rl);
    int k, lo, hi;
    k = 0;
    // Counting begins two edges after the load, so up to three ticks short
    lo = 2 * (sv + 1) * (2 << p) - 3;
    hi = 2 * (sv + 1) * (2 << p);
    @(posedge clk);
    cfg[i] <= '{20'(sv), 3'(p), CRT_ST_NOW, rl, 1'b1};
    repeat (3) @(posedge clk);
    #1;
    chk(20'(run[i]), 20'h1);
    for (int w = 0; w < 8000 && exp_f[i] !== 1'b1; w++) begin
      @(posedge clk);
      #1;
      if ((clk_src_rf ? tick_rf_27m : tick_pll_27m) === 1'b1) k++;
    end
    chk(20'(k >= lo && k <= hi), 20'h1);
    chk(20'({exp_f[i], irq, run[i]}), 20'({2'b11, rl}));
    if (rl) chk(cnt[i], 20'(sv));
    @(posedge clk);
    cfg[i].enable <= 1'b0;
    fclr[i] <= 1'b1;
    @(posedge clk);
    fclr <= 3'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(20'({exp_f[i], irq, run[i]}), 20'h0);
    $display("test expire timer %0d prescale %0d done", i, p);
  endtask : expire

  // Trim timer from a software start; hfo edges come far faster
  task automatic trim(input logic h, input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clk);
    t_hfo <= h;
    t_start <= 1'b1;
    @(posedge clk);
    t_start <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(20'(t_run), 20'h1);
    while (t_exp !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(20'(n >= lo && n <= hi), 20'h1);
    chk(20'({t_exp, t_run, irq}), 20'h5);
    @(posedge clk);
    t_fclr <= 1'b1;
    @(posedge clk);
    t_fclr <= 1'b0;
    $display("test trim hfo=%0d done", h);
  endtask : trim

  initial begin
    {resetn, clk_src_rf, pll_on, rf_on, t_start, t_stop, t_hfo} = '0;
    {t_fclr, fclr, ev} = '0;
    rf_clock_present = 1'b1;
    t_sv = 20'h3;
    cfg = '{default: '0};
    n_mismatch = 0;
    checked = 0;
    seed = 32'hc9b3;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    pll_on <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(20'({run, exp_f, t_run, t_exp, irq}), 20'h0);
    // Every prescale code with a short random start value
    for (int p = 0; p < 8; p++) expire(0, 2 + rnd() % 3, p, 1'b0);
    expire(0, 1, 0, 1'b1);
    // Each event trigger: armed timer waits, then its event starts it
    for (int t = 1; t < 7; t++) begin
      @(posedge clk);
      cfg[1] <= '{20'(100 + rnd() % 900), 3'h0, crt_start_t'(t), 1'b0, 1'b1};
      repeat (2) @(posedge clk);
      // Every other event first; none of them may start the timer
      ev <= crt_evt_t'(~(6'h1 << (6 - t)));
      @(posedge clk);
      ev <= '0;
      repeat (2) @(posedge clk);
      #1;
      chk(20'(run[1]), 20'h0);
      @(posedge clk);
      ev <= crt_evt_t'(6'h1 << (6 - t));
      @(posedge clk);
      ev <= '0;
      repeat (2) @(posedge clk);
      #1;
      chk(20'(run[1]), 20'h1);
      @(posedge clk);
      cfg[1].enable <= 1'b0;
    end
    $display("test triggers done");
    // Trim timer refused without contactless clock; timer c waits on it
    @(posedge clk);
    cfg[2] <= '{20'hfffff, 3'h7, CRT_ST_OSC_RUN, 1'b0, 1'b1};
    rf_clock_present <= 1'b0;
    t_start <= 1'b1;
    @(posedge clk);
    t_start <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(20'(t_run), 20'h0);
    chk(20'(run[2]), 20'h0);
    @(posedge clk);
    rf_clock_present <= 1'b1;
    trim(1'b0, 46, 63);
    #1;
    chk(20'(run[2]), 20'h1);
    trim(1'b1, 10, 19);
    // Contactless clock taken from field recovery instead of PLL
    @(posedge clk);
    cfg[2].enable <= 1'b0;
    pll_on <= 1'b0;
    rf_on <= 1'b1;
    clk_src_rf <= 1'b1;
    expire(1, 3, 1, 1'b0);
    wrap_up();
  end

  // Tests need about 4000 cycles; allow fifteen times that
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule : contactless_rf_timers_tb_top
